/* File: hdl/uis_pkg.sv */
package uis_pkg;
  // Serial frame layout
  localparam int UIS_FRAME_BITS = 16;
  localparam logic [4:0] UIS_LAST_PULSE = 5'h0F;
  localparam logic [4:0] UIS_CMD_PULSE = 5'h01;
  localparam logic [4:0] UIS_FIRST_PULSE = 5'h00;
  localparam logic [3:0] UIS_MSB_IDX = 4'hF;
  // Status word field positions
  localparam int UIS_BIT_RX_AVAIL = 15;
  localparam int UIS_BIT_TX_EMPTY = 14;
  localparam int UIS_BIT_AF = 10;
  localparam int UIS_BIT_CTS = 9;
  localparam int UIS_BIT_PARITY = 8;
  localparam int UIS_DATA_W = 8;
  // Receive buffer default depth
  localparam int UIS_FIFO_DEPTH = 8;
  // Reset values
  localparam logic UIS_RST_IRQ_N = 1'h1;
  localparam logic UIS_RST_OSC_ON = 1'h1;
  localparam logic UIS_RST_TX_EMPTY = 1'h1;
  // Power state of the UART core
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_DRAIN,
    PWR_SHUT,
    PWR_WAKE
  } uis_pwr_e;
endpackage

/* File: hdl/uis_core.sv */
// Operation
// RULE1: Parity flag set when checking is on and oldest word's parity is 1.
// RULE2: Parity flag clear when checking is off or oldest word's parity is 0.
// RULE3: Parity interrupt follows the oldest buffer entry, the next one read.
// RULE4: Data-available high while data waits or is read; interrupts with its mask.
// RULE5: Buffer counts as empty once every stored word was read.
// RULE6: In shutdown any receive pin transition sets the activity flag.
// RULE7: Activity indication clears when leaving shutdown.
// RULE8: In shutdown activity flag with its mask raises the interrupt.
// RULE9: Framing flag comes from the current character only, never buffered.
// RULE10: Framing flag set when first stop bit samples as zero.
// RULE11: Framing flag clears on next good character; interrupts with its mask.
// RULE12: Transmit-empty flag high whenever the transmit buffer accepts a word.
// RULE13: Interrupt asserted when transmit mask set and transmit buffer becomes empty.
// RULE14: Transmit source clears on 16th clock of data op or read select rise.
// RULE15: Host polls transmit-empty flag; clearing the source leaves it unchanged.
// RULE16: Shutdown request stops oscillator and sets shutdown state once entered.
// RULE17: Shutdown waits until transmit shifter and holding buffer are done.
// RULE18: Shutdown entry empties buffer, clears flags and data, forces transmit-empty.
// RULE19: Masks and settings stay writable and handshake input readable in shutdown.
// RULE20: Dropping the request restarts the oscillator when select returns high.
// RULE21: Host waits for oscillator settling before reconfiguring.
// RULE22: Interrupt releases once no raising condition remains.
// RULE23: Every data op returns data-available in bit 15, transmit-empty in 14.
// RULE24: Interrupt is the OR of four masked sources, active low.
`timescale 1ns/1ps
module uis_core
  import uis_pkg::*;
#(
  parameter int DEPTH = UIS_FIFO_DEPTH
)
(
  input wire logic i_clock, // System clock, 125 MHz
  input wire logic i_sys_rst, // Async reset, active high
  input wire logic i_sclk, // Serial link clock
  input wire logic i_cs_n, // Link chip select, active low
  input wire logic i_din, // Link serial data in
  input wire logic i_parity_check_on, // Parity checking enabled
  input wire logic i_parity_irq_mask, // Parity interrupt mask
  input wire logic i_rx_avail_irq_mask, // Data-available interrupt mask
  input wire logic i_af_irq_mask, // Activity/framing interrupt mask
  input wire logic i_tx_empty_irq_mask, // Transmit-empty interrupt mask
  input wire logic i_shutdown_request, // Software shutdown request
  input wire logic i_cts_n, // Handshake input pin, active low
  input wire logic i_rx_pin, // Serial receive pin
  input wire logic i_rx_push, // Received word strobe
  input wire logic [UIS_DATA_W-1:0] i_rx_data, // Received word
  input wire logic i_rx_parity, // Received parity bit
  input wire logic i_stop_strobe, // First stop bit sampled
  input wire logic i_stop_level, // Level of that stop bit
  input wire logic i_tx_buf_empty, // Holding buffer can take a word
  input wire logic i_tx_shift_idle, // Transmit shifter idle
  output logic o_dout, // Link serial data out
  output logic o_irq_n, // Interrupt, active low
  output logic o_shutdown_state, // Core is shut down
  output logic o_osc_on, // Oscillator enable
  output logic o_rx_avail, // Data-available flag
  output logic o_tx_empty, // Transmit-empty flag
  output logic o_rx_parity_flag, // Oldest word parity flag
  output logic o_activity_framing_flag, // Activity or framing flag
  output logic o_rx_full, // Receive buffer full
  output logic o_shutdown_clear // Pulse: clear data and tx parity
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  // Link side, cleared between frames by the select itself
  typedef struct packed {
    logic [4:0] cnt;
    logic b15;
    logic rd_flag;
    logic is_data;
  } uis_frame_s;

  // Link side event toggle, survives between frames
  typedef struct packed {
    logic done_tgl;
  } uis_link_s;

  typedef struct packed {
    logic cs_m, cs_s, cs_d;
    logic sclk_m, sclk_s, sclk_d;
    logic rx_m, rx_s, rx_d;
    logic cts_m, cts_s;
    logic tg_m, tg_s, tg_d;
    logic rd_m, rd_s;
    logic rd_frame;
    logic being_read;
    logic [3:0] out_idx;
    logic [UIS_FRAME_BITS-1:0] snap;
    logic dout;
    logic [DEPTH-1:0][UIS_DATA_W:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic fe;
    logic act;
    logic txe_d;
    logic tx_pend;
    uis_pwr_e pwr;
    logic shut;
    logic shut_clr;
    logic osc_on;
    logic irq_n;
    logic avail;
    logic txe;
    logic par;
    logic af;
    logic full;
  } uis_sys_s;

  uis_frame_s frame, next_frame;
  uis_link_s link, next_link;
  uis_sys_s s, next_s;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  // Command decode and pulse count on rising link clock
  always_comb
  begin
    next_frame = frame;
    next_link = link;
    if (frame.cnt != 5'(UIS_FRAME_BITS))
    begin
      next_frame.cnt = frame.cnt + 5'h01;
    end
    if (frame.cnt == UIS_FIRST_PULSE)
    begin
      next_frame.b15 = i_din;
    end
    if (frame.cnt == UIS_CMD_PULSE)
    begin
      next_frame.is_data = ~i_din;
      next_frame.rd_flag = ~frame.b15 & ~i_din;
    end
    // Only data reads and writes report completion
    if (frame.cnt == UIS_LAST_PULSE && frame.is_data)
    begin
      next_link.done_tgl = ~link.done_tgl; // RULE14
    end
  end

  // Select high restarts the count, so an aborted frame cannot desync
  always_ff @(posedge i_sclk or posedge i_sys_rst or posedge i_cs_n)
  begin
    if (i_sys_rst || i_cs_n)
    begin
      frame <= '0;
    end
    else
    begin
      frame <= next_frame;
    end
  end

  always_ff @(posedge i_sclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      link <= '0;
    end
    else
    begin
      link <= next_link;
    end
  end

  // System side: sync, buffer, flags, power and interrupt
  always_comb
  begin
    logic cs_rise;
    logic cs_fall;
    logic sclk_fall;
    logic done;
    logic pop;
    logic push;
    logic rx_edge;
    logic tx_became_empty;
    logic shut_now;
    logic src_par;
    logic src_avail;
    logic src_af;
    cs_rise = 1'b0;
    cs_fall = 1'b0;
    sclk_fall = 1'b0;
    done = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    rx_edge = 1'b0;
    tx_became_empty = 1'b0;
    shut_now = 1'b0;
    src_par = 1'b0;
    src_avail = 1'b0;
    src_af = 1'b0;
    next_s = s;
    next_s.shut_clr = 1'b0;
    // Two-flop synchronisers, first stage read only by the second
    next_s.cs_m = i_cs_n;
    next_s.cs_s = s.cs_m;
    next_s.cs_d = s.cs_s;
    next_s.sclk_m = i_sclk;
    next_s.sclk_s = s.sclk_m;
    next_s.sclk_d = s.sclk_s;
    next_s.rx_m = i_rx_pin;
    next_s.rx_s = s.rx_m;
    next_s.rx_d = s.rx_s;
    next_s.cts_m = i_cts_n;
    next_s.cts_s = s.cts_m;
    next_s.tg_m = link.done_tgl;
    next_s.tg_s = s.tg_m;
    next_s.tg_d = s.tg_s;
    next_s.rd_m = frame.rd_flag;
    next_s.rd_s = s.rd_m;
    cs_rise = s.cs_s & ~s.cs_d;
    cs_fall = ~s.cs_s & s.cs_d;
    sclk_fall = ~s.sclk_s & s.sclk_d;
    done = s.tg_s ^ s.tg_d;
    rx_edge = s.rx_s ^ s.rx_d;
    // Latched read kind, since the link flag drops with the select
    if (s.rd_s)
    begin
      next_s.rd_frame = 1'b1;
    end
    if (cs_rise)
    begin
      next_s.rd_frame = 1'b0;
      next_s.being_read = 1'b0;
    end
    if (cs_fall)
    begin
      next_s.being_read = (s.count != '0); // RULE4
    end
    // Receive buffer; pop on every completed data read or write
    pop = done && (s.count != '0) && !s.shut; // RULE5
    push = i_rx_push && (s.count != FULL_CNT) && !s.shut;
    if (push)
    begin
      next_s.mem[s.wr_ptr] = {i_rx_parity, i_rx_data};
      next_s.wr_ptr = ptr_inc(s.wr_ptr);
    end
    if (pop)
    begin
      next_s.rd_ptr = ptr_inc(s.rd_ptr);
    end
    next_s.count = s.count + (AW + 1)'(push) - (AW + 1)'(pop);
    // Framing error tracks the latest character only
    if (!s.shut && i_stop_strobe)
    begin
      next_s.fe = ~i_stop_level; // RULE9 RULE10 RULE11
    end
    if (s.shut && rx_edge)
    begin
      next_s.act = 1'b1; // RULE6
    end
    // Transmit source: set on becoming empty, set wins over clear
    next_s.txe_d = i_tx_buf_empty;
    tx_became_empty = i_tx_buf_empty & ~s.txe_d;
    if (done || (cs_rise && s.rd_frame))
    begin
      next_s.tx_pend = 1'b0; // RULE14
    end
    if (tx_became_empty)
    begin
      next_s.tx_pend = 1'b1; // RULE13
    end
    // Power sequencing
    case (s.pwr)
      PWR_RUN:
      begin
        if (i_shutdown_request)
        begin
          next_s.pwr = PWR_DRAIN;
        end
      end
      PWR_DRAIN:
      begin
        if (!i_shutdown_request)
        begin
          next_s.pwr = PWR_RUN;
        end
        else if (i_tx_buf_empty && i_tx_shift_idle) // RULE17
        begin
          next_s.pwr = PWR_SHUT; // RULE16
          next_s.osc_on = 1'b0;
          next_s.count = '0; // RULE18
          next_s.rd_ptr = '0;
          next_s.wr_ptr = '0;
          next_s.being_read = 1'b0;
          next_s.fe = 1'b0;
          next_s.act = 1'b0;
          next_s.shut_clr = 1'b1;
        end
      end
      PWR_SHUT:
      begin
        if (!i_shutdown_request)
        begin
          next_s.pwr = PWR_WAKE;
        end
      end
      PWR_WAKE:
      begin
        if (i_shutdown_request)
        begin
          next_s.pwr = PWR_SHUT;
        end
        else if (cs_rise)
        begin
          next_s.pwr = PWR_RUN; // RULE20
          next_s.osc_on = 1'b1;
          next_s.act = 1'b0; // RULE7
        end
      end
      default:
      begin
        next_s.pwr = PWR_RUN;
      end
    endcase
    shut_now = (next_s.pwr == PWR_SHUT) || (next_s.pwr == PWR_WAKE);
    next_s.shut = shut_now;
    // Registered flags; the mask inputs stay live in shutdown
    src_avail = (next_s.count != '0) || next_s.being_read; // RULE4
    src_par = i_parity_check_on && (next_s.count != '0) && next_s.mem[next_s.rd_ptr][UIS_DATA_W]; // RULE1 RULE2 RULE3
    src_af = shut_now ? next_s.act : next_s.fe;
    next_s.avail = src_avail;
    next_s.par = src_par;
    next_s.af = src_af;
    next_s.txe = shut_now || i_tx_buf_empty; // RULE12 RULE18
    next_s.full = (next_s.count == FULL_CNT);
    next_s.irq_n = ~((src_par && i_parity_irq_mask) || (src_avail && i_rx_avail_irq_mask)
                     || (src_af && i_af_irq_mask) || (next_s.tx_pend && i_tx_empty_irq_mask)); // RULE24 RULE22 RULE19
    // Status word follows live flags until the frame starts, then freezes
    if (s.cs_s)
    begin
      next_s.snap = '0;
      next_s.snap[UIS_BIT_RX_AVAIL] = s.avail; // RULE23
      next_s.snap[UIS_BIT_TX_EMPTY] = s.txe;
      next_s.snap[UIS_BIT_AF] = s.af;
      next_s.snap[UIS_BIT_CTS] = ~s.cts_s; // RULE19
      next_s.snap[UIS_BIT_PARITY] = s.par;
      next_s.snap[UIS_DATA_W-1:0] = (s.count != '0) ? s.mem[s.rd_ptr][UIS_DATA_W-1:0] : '0;
      next_s.out_idx = '0;
    end
    else if (sclk_fall && s.out_idx != UIS_MSB_IDX)
    begin
      next_s.out_idx = s.out_idx + 4'h1;
    end
    next_s.dout = next_s.snap[UIS_MSB_IDX - next_s.out_idx];
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      s <= '0;
      s.cs_m <= 1'b1;
      s.cs_s <= 1'b1;
      s.cs_d <= 1'b1;
      s.pwr <= PWR_RUN;
      s.osc_on <= UIS_RST_OSC_ON;
      s.irq_n <= UIS_RST_IRQ_N;
      s.txe <= UIS_RST_TX_EMPTY;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign o_dout = s.dout;
  assign o_irq_n = s.irq_n;
  assign o_shutdown_state = s.shut;
  assign o_osc_on = s.osc_on;
  assign o_rx_avail = s.avail;
  assign o_tx_empty = s.txe;
  assign o_rx_parity_flag = s.par;
  assign o_activity_framing_flag = s.af;
  assign o_rx_full = s.full;
  assign o_shutdown_clear = s.shut_clr;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  a_parity_off: assert property (!i_parity_check_on |=> !o_rx_parity_flag) // RULE2
    else $error("parity flag set while checking off");
  a_parity_set: assert property ($rose(o_rx_parity_flag) |-> $past(i_parity_check_on) && o_rx_avail) // RULE1
    else $error("parity flag rose without cause");
  a_avail_irq: assert property (o_rx_avail && $past(i_rx_avail_irq_mask) |-> !o_irq_n) // RULE4
    else $error("data available but no interrupt");
  a_push_avail: assert property (i_rx_push && !o_rx_full && s.pwr == PWR_RUN |=> o_rx_avail) // RULE5
    else $error("pushed word not reported");
  a_act_set: assert property (s.pwr == PWR_SHUT && (s.rx_s ^ s.rx_d) |=> o_activity_framing_flag) // RULE6
    else $error("activity not flagged in shutdown");
  a_act_exit: assert property ($fell(o_shutdown_state) |-> !o_activity_framing_flag) // RULE7
    else $error("activity flag survived wakeup");
  a_af_irq: assert property (o_activity_framing_flag && $past(i_af_irq_mask) |-> !o_irq_n) // RULE8
    else $error("activity or framing without interrupt");
  a_fe_set: assert property (s.pwr == PWR_RUN && i_stop_strobe && !i_stop_level |=> o_activity_framing_flag) // RULE10
    else $error("framing error missed");
  a_fe_clear: assert property (s.pwr == PWR_RUN && i_stop_strobe && i_stop_level |=> !o_activity_framing_flag) // RULE11
    else $error("framing error not cleared");
  a_tx_irq: assert property (s.tx_pend && $past(i_tx_empty_irq_mask) |-> !o_irq_n) // RULE13
    else $error("transmit empty without interrupt");
  a_tx_src_clear: assert property ((s.tg_s ^ s.tg_d) && !(i_tx_buf_empty && !s.txe_d) |=> !s.tx_pend) // RULE14
    else $error("transmit source not cleared");
  a_shut_defer: assert property ($rose(o_shutdown_state) |-> $past(i_tx_buf_empty && i_tx_shift_idle)) // RULE17
    else $error("shutdown entered while transmitting");
  a_shut_clear: assert property ($rose(o_shutdown_state) |-> !o_rx_avail && o_tx_empty && !o_osc_on ##1 !o_rx_avail) // RULE18
    else $error("shutdown entry did not clear state");
  a_wake_cs: assert property ($fell(o_shutdown_state) |-> $past(s.cs_s && !s.cs_d) && o_osc_on) // RULE20
    else $error("wakeup without select rise");
  a_irq_release: assert property (!o_rx_avail && !o_activity_framing_flag && !o_rx_parity_flag && !s.tx_pend |-> o_irq_n) // RULE22
    else $error("interrupt held without source");
  a_status_bits: assert property (s.cs_s |=> s.snap[15] == $past(o_rx_avail) && s.snap[14] == $past(o_tx_empty)) // RULE23
    else $error("status word flags wrong");

  c_pop: cover property ((s.tg_s ^ s.tg_d) && o_rx_avail);
  c_shutdown: cover property ($rose(o_shutdown_state));
  c_wakeup: cover property ($fell(o_shutdown_state));
  c_framing: cover property ($rose(o_activity_framing_flag) && !o_shutdown_state);
endmodule

/* File: sim/uis_host.sv */
`timescale 1ns/1ps
module uis_host
(
  input wire logic i_dout, // Status bit from the device
  output logic o_sclk, // Link clock, still between frames
  output logic o_cs_n, // Select, active low
  output logic o_din, // Command bit, MSB first
  output logic o_done, // Pulse when a frame ends
  output logic [15:0] o_word // Captured status word
);
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b1;
    o_done = 1'b0;
    o_word = 16'h0000;
  end

  // One frame of n pulses at a 64 ns period, offset in phase from the system clock
  task automatic frame(input logic [15:0] cmd, input int n);
    #5;
    o_cs_n = 1'b0;
    o_din = cmd[15];
    #48;
    for (int i = 15; i > 15 - n; i--)
    begin
      o_sclk = 1'b1;
      #32;
      o_word[i] = i_dout; // Taken late in the high phase, the bit has settled
      o_sclk = 1'b0;
      if (i > 0) o_din = cmd[i-1];
      #32;
    end
    o_cs_n = 1'b1;
    o_din = ~o_din; // Released line does not keep its last value
    o_done = 1'b1;
    #1;
    o_done = 1'b0;
    #80; // Select stays high well past the minimum gap
  endtask
endmodule

/* File: sim/tb_uart_irq_and_soft_shutdown.sv */
`timescale 1ns/1ps
`define CHK(nm, e, a) \
  n_compared++; \
  if ((a) !== (e)) \
  begin \
    $display("BAD %s exp=%h got=%h", nm, e, a); \
    error_cnt++; \
  end
module tb_uart_irq_and_soft_shutdown;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic sclk, cs_n, din, dout, f_done;
  logic [15:0] f_word, e_w;
  logic par_on = 1'b0, pm = 1'b0, rm = 1'b0, afm = 1'b0, tm = 1'b0;
  logic sd_req = 1'b0, cts_n = 1'b0, rx_pin = 1'b1, push = 1'b0, rx_par = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic stb = 1'b0, stb_lvl = 1'b1, txb_empty = 1'b1, tx_idle = 1'b1;
  logic irq_n, sd_st, osc_on, avail, tx_empty, par_f, af, full, sd_clr;
  logic [7:0] wa, wb;
  logic [15:0] exp_q[$];
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_clr = 0;

  always #4 i_clock = ~i_clock;

  uis_core uis_core_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_din(din), .i_parity_check_on(par_on), .i_parity_irq_mask(pm), .i_rx_avail_irq_mask(rm),
    .i_af_irq_mask(afm), .i_tx_empty_irq_mask(tm), .i_shutdown_request(sd_req), .i_cts_n(cts_n),
    .i_rx_pin(rx_pin), .i_rx_push(push), .i_rx_data(rx_data), .i_rx_parity(rx_par),
    .i_stop_strobe(stb), .i_stop_level(stb_lvl), .i_tx_buf_empty(txb_empty),
    .i_tx_shift_idle(tx_idle), .o_dout(dout), .o_irq_n(irq_n), .o_shutdown_state(sd_st),
    .o_osc_on(osc_on), .o_rx_avail(avail), .o_tx_empty(tx_empty), .o_rx_parity_flag(par_f),
    .o_activity_framing_flag(af), .o_rx_full(full), .o_shutdown_clear(sd_clr));

  uis_host uis_host_inst (.i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din),
    .o_done(f_done), .o_word(f_word));

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Outputs are looked at mid-cycle so edge updates have landed
  task automatic look(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask

  task automatic put(input logic [7:0] d, input logic p);
    @(posedge i_clock);
    push <= 1'b1;
    rx_data <= d;
    rx_par <= p;
    @(posedge i_clock);
    push <= 1'b0;
  endtask

  task automatic stop_bit(input logic lvl);
    @(posedge i_clock);
    stb <= 1'b1;
    stb_lvl <= lvl;
    @(posedge i_clock);
    stb <= 1'b0;
  endtask

  // Full frames note the status word they should return
  task automatic xfer(input logic [15:0] cmd, input int n, input logic [15:0] e);
    if (n == 16) exp_q.push_back(e);
    @(posedge i_clock);
    uis_host_inst.frame(cmd, n);
  endtask

  // Each full frame is matched against the oldest note; short frames leave no note
  always @(posedge f_done)
  begin
    if (exp_q.size() > 0)
    begin
      e_w = exp_q.pop_front();
      `CHK("status word", e_w, f_word)
    end
  end

  // Count shutdown clear pulses, too short to catch by looking mid-test
  always @(posedge i_clock)
  begin
    if (sd_clr === 1'b1)
      n_clr++;
  end

  // Hang guard: the whole run needs far fewer cycles
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      $display("BAD timeout exp=0 got=%0d", cyc);
      error_cnt++;
      conclude();
    end
  end

  initial
  begin
    void'($urandom(32'h4c8ae23c));
    wa = 8'($urandom());
    wb = 8'($urandom());
    repeat (10) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    look(4);
    `CHK("irq_n", 1'b1, irq_n)
    `CHK("osc_on", 1'b1, osc_on)
    `CHK("tx_empty", 1'b1, tx_empty)
    `CHK("sd_state", 1'b0, sd_st)
    $display("test reset done");

    @(posedge i_clock);
    par_on <= 1'b1;
    rm <= 1'b1;
    cts_n <= 1'($urandom());
    put(wa, 1'b1);
    put(wb, 1'b0);
    look(2);
    `CHK("avail", 1'b1, avail)
    `CHK("par_flag", 1'b1, par_f)
    `CHK("irq_n", 1'b0, irq_n)
    @(posedge i_clock);
    par_on <= 1'b0;
    look(2);
    `CHK("par_flag", 1'b0, par_f)
    @(posedge i_clock);
    par_on <= 1'b1;
    xfer(16'h0000, 16, {2'b11, 3'b000, 1'b0, ~cts_n, 1'b1, wa});
    look(2);
    `CHK("par_flag", 1'b0, par_f)
    `CHK("avail", 1'b1, avail)
    xfer(16'h0000, 16, {2'b11, 3'b000, 1'b0, ~cts_n, 1'b0, wb});
    look(2);
    `CHK("avail", 1'b0, avail)
    `CHK("irq_n", 1'b1, irq_n)
    $display("test receive done");

    @(posedge i_clock);
    rm <= 1'b0;
    afm <= 1'b1;
    stop_bit(1'b0);
    look(2);
    `CHK("af", 1'b1, af)
    `CHK("irq_n", 1'b0, irq_n)
    put(wa, 1'b1);
    look(2);
    `CHK("af", 1'b1, af)
    stop_bit(1'b1);
    look(2);
    `CHK("af", 1'b0, af)
    `CHK("irq_n", 1'b1, irq_n)
    xfer(16'h0000, 16, {2'b11, 3'b000, 1'b0, ~cts_n, 1'b1, wa});
    $display("test framing done");

    @(posedge i_clock);
    txb_empty <= 1'b0;
    tm <= 1'b1;
    look(3);
    `CHK("tx_empty", 1'b0, tx_empty)
    `CHK("irq_n", 1'b1, irq_n)
    @(posedge i_clock);
    txb_empty <= 1'b1;
    look(4);
    `CHK("tx_empty", 1'b1, tx_empty)
    `CHK("irq_n", 1'b0, irq_n)
    xfer(16'h8000, 16, {2'b01, 3'b000, 1'b0, ~cts_n, 1'b0, 8'h00});
    look(2);
    `CHK("irq_n", 1'b1, irq_n)
    `CHK("tx_empty", 1'b1, tx_empty)
    @(posedge i_clock);
    txb_empty <= 1'b0;
    look(3);
    @(posedge i_clock);
    txb_empty <= 1'b1;
    look(4);
    `CHK("irq_n", 1'b0, irq_n)
    xfer(16'h0000, 8, 16'h0000);
    look(2);
    `CHK("irq_n", 1'b1, irq_n)
    @(posedge i_clock);
    tm <= 1'b0;
    $display("test transmit done");

    put(wa, 1'b1);
    @(posedge i_clock);
    tx_idle <= 1'b0;
    sd_req <= 1'b1;
    look(10);
    `CHK("sd_state", 1'b0, sd_st)
    `CHK("osc_on", 1'b1, osc_on)
    @(posedge i_clock);
    tx_idle <= 1'b1;
    for (int k = 0; k < 20 && sd_st !== 1'b1; k++) look(0);
    look(2);
    `CHK("sd_state", 1'b1, sd_st)
    `CHK("osc_on", 1'b0, osc_on)
    `CHK("avail", 1'b0, avail)
    `CHK("par_flag", 1'b0, par_f)
    `CHK("tx_empty", 1'b1, tx_empty)
    `CHK("sd_clear", 1, n_clr)
    `CHK("irq_n", 1'b1, irq_n)
    @(posedge i_clock);
    rx_pin <= 1'b0;
    look(6);
    `CHK("af", 1'b1, af)
    `CHK("irq_n", 1'b0, irq_n)
    @(posedge i_clock);
    afm <= 1'b0;
    look(3);
    `CHK("irq_n", 1'b1, irq_n)
    put(wb, 1'b1);
    look(2);
    `CHK("avail", 1'b0, avail)
    xfer(16'h0000, 16, {2'b01, 3'b000, 1'b1, ~cts_n, 1'b0, 8'h00});
    @(posedge i_clock);
    sd_req <= 1'b0;
    look(3);
    `CHK("sd_state", 1'b1, sd_st)
    xfer(16'h0000, 8, 16'h0000);
    look(8);
    `CHK("osc_on", 1'b1, osc_on)
    `CHK("sd_state", 1'b0, sd_st)
    `CHK("af", 1'b0, af)
    $display("test shutdown done");
    // Fill the buffer to its default depth of eight words
    `CHK("full", 1'b0, full)
    repeat (8) put(wb, 1'b0);
    look(2);
    `CHK("full", 1'b1, full)
    `CHK("avail", 1'b1, avail)
    `CHK("notes left", 0, exp_q.size())
    $display("test full done");
    look(4);
    conclude();
  end
endmodule
